// ==== hw/ftb_pkg.sv ====
// Operation
// [RULE1] each accumulator counts up to ten million
// [RULE2] at ten million: overflow plus one, wrap to zero
// [RULE3] any wrap raises a visible warning
// [RULE4] overflow counter is sixteen bits wide
// [RULE5] each accumulator loadable alone; zero clears it
// [RULE6] preset or clear also zeroes its overflow counter
// [RULE7] confirmed global clear zeroes all accumulators together
// [RULE8] forward-only mode hides the reverse accumulators
// [RULE9] forward accumulator per quantity, range zero..ten million
// [RULE10] separate reverse accumulator per quantity, same range
// [RULE11] overflow counters are read-only to software
// [RULE12] each overflow weighs ten million units
// [RULE13] overflow counter saturates at 65535
// [RULE14] increments routed by present flow direction
package ftb_pkg;
    // ------------------------------------------------------------
    // bank layout
    // ------------------------------------------------------------
    localparam int QTY_N = 3;                 // mass, volume, net mass
    localparam int ACC_N = 6;                 // index = quantity*2 + reverse
    localparam int ACC_W = 24;
    localparam int OVF_W = 16;
    localparam logic [ACC_W-1:0] ACC_LIMIT = 24'h989680;   // ten million
    localparam logic [OVF_W-1:0] OVF_MAX = 16'hffff;
    localparam logic [ACC_W-1:0] ACC_RST = 24'h000000;
    localparam logic [OVF_W-1:0] OVF_RST = 16'h0000;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 32'h00000000;
    localparam logic [ADDR_W-1:0] OFS_GCLR = 32'h00000004;
    localparam logic [ADDR_W-1:0] OFS_ISTS = 32'h00000008;
    localparam logic [ADDR_W-1:0] OFS_IMSK = 32'h0000000c;
    localparam logic [ADDR_W-1:0] OFS_STAT = 32'h00000010;
    localparam logic [ADDR_W-1:0] OFS_ACC_BASE = 32'h00000020;
    localparam logic [ADDR_W-1:0] OFS_ACC_END = 32'h00000050;
    localparam int ACC_STRIDE_SH = 3;         // 8 bytes per accumulator
    localparam int OVF_SEL_BIT = 2;           // +4 selects overflow word
    localparam int CTRL_FWD_BIT = 0;
    localparam int STAT_REV_BIT = 0;
    localparam int STAT_WARN_BIT = 1;
    localparam logic [DATA_W-1:0] GCLR_KEY = 32'h0000c1ea;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hw/ftb_acc_if.sv ====
`timescale 1ns/1ps
// control and readback of one accumulator
interface ftb_acc_if;
    logic inc;
    logic load;
    logic [ftb_pkg::ACC_W-1:0] load_val;
    logic gclr;
    logic [ftb_pkg::ACC_W-1:0] value;
    logic [ftb_pkg::OVF_W-1:0] ovf;
    logic wrap;
    modport ctl (output inc, output load, output load_val, output gclr,
                 input value, input ovf, input wrap);
    modport acc (input inc, input load, input load_val, input gclr,
                 output value, output ovf, output wrap);
endinterface

// ==== hw/ftb_acc.sv ====
`timescale 1ns/1ps
module ftb_acc (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control side
    ftb_acc_if.acc bus
);
    import ftb_pkg::*;

    logic [ACC_W:0] sum;
    logic hit;
    logic [ACC_W-1:0] load_c;

    // ------------------------------------------------------------
    // next count and wrap detection
    // ------------------------------------------------------------
    assign sum = {1'b0, bus.value} + (ACC_W+1)'(1);
    assign hit = bus.inc && (sum >= {1'b0, ACC_LIMIT});       // [RULE1]
    // loads above the range are pinned to the top reading
    assign load_c = (bus.load_val > ACC_LIMIT) ? ACC_LIMIT : bus.load_val;

    // reading: clear beats load beats count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus.value <= ACC_RST;
        end else if (bus.gclr) begin
            bus.value <= ACC_RST;                              // [RULE7]
        end else if (bus.load) begin
            bus.value <= load_c;                               // [RULE5]
        end else if (hit) begin
            bus.value <= ACC_W'(sum - {1'b0, ACC_LIMIT});      // [RULE2]
        end else if (bus.inc) begin
            bus.value <= sum[ACC_W-1:0];                       // [RULE1]
        end
    end

    // overflow counter, no software write path exists
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus.ovf <= OVF_RST;
        end else if (bus.gclr || bus.load) begin
            bus.ovf <= OVF_RST;                                // [RULE6]
        end else if (hit && bus.ovf != OVF_MAX) begin
            bus.ovf <= bus.ovf + OVF_W'(1);                    // [RULE2] [RULE4] [RULE13]
        end
    end

    // one-cycle wrap event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus.wrap <= 1'b0;
        end else begin
            bus.wrap <= hit && !bus.gclr && !bus.load;         // [RULE3]
        end
    end
endmodule

// ==== hw/ftb_top.sv ====
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module ftb_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ftb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [ftb_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ftb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [ftb_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // flow measurement
    input wire logic [ftb_pkg::QTY_N-1:0] flow_inc,
    input wire logic flow_reverse,
    // indications
    output logic warn,
    output logic irq
);
    import ftb_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // accumulator index of an address, IDX_NONE when outside the bank
    function automatic logic [2:0] acc_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFS_ACC_BASE;
        if (a >= OFS_ACC_BASE && a < OFS_ACC_END && a[1:0] == 2'h0) begin
            acc_idx = d[ACC_STRIDE_SH+2:ACC_STRIDE_SH];
        end else begin
            acc_idx = IDX_NONE;
        end
    endfunction

    // reverse slots vanish in forward-only mode
    function automatic logic acc_avail(input logic [2:0] i, input logic fwd);
        acc_avail = (i != IDX_NONE) && !(i[0] && fwd);
    endfunction

    // byte-lane merge of a write onto the old word
    function automatic logic [DATA_W-1:0] strb_merge(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] nw,
                                                    input logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        strb_merge = r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic fwd_only_r;
    logic [ACC_N-1:0] ists_r;
    logic [ACC_N-1:0] imsk_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_have_r;
    logic w_have_r;
    logic do_write;
    logic [2:0] w_idx;
    logic w_ovf;
    logic w_ok;
    logic gclr_go;
    logic [ACC_N-1:0] wrap_v;
    logic [ACC_W-1:0] acc_val [ACC_N];
    logic [OVF_W-1:0] acc_ovf [ACC_N];

    ftb_acc_if acc_bus [ACC_N] ();

    // ------------------------------------------------------------
    // accumulator bank
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < ACC_N; g++) begin : g_acc
            // odd slots are reverse, even slots forward
            assign acc_bus[g].inc = flow_inc[g/2] &&
                (flow_reverse == (g % 2 == 1)) &&                 // [RULE14]
                !((g % 2 == 1) && fwd_only_r);                    // [RULE8]
            assign acc_bus[g].load = do_write && w_idx == 3'(g) && !w_ovf &&
                acc_avail(w_idx, fwd_only_r);                      // [RULE5] [RULE9] [RULE10]
            logic [DATA_W-1:0] merged;
            assign merged = strb_merge({{(DATA_W-ACC_W){1'b0}}, acc_bus[g].value},
                wdata_r, wstrb_r);
            // pinned on the full word so set upper bytes cannot fold back into range
            assign acc_bus[g].load_val = (merged > {{(DATA_W-ACC_W){1'b0}}, ACC_LIMIT}) ?
                ACC_LIMIT : merged[ACC_W-1:0];
            assign acc_bus[g].gclr = gclr_go;                      // [RULE7]
            assign acc_val[g] = acc_bus[g].value;
            assign acc_ovf[g] = acc_bus[g].ovf;
            assign wrap_v[g] = acc_bus[g].wrap;

            ftb_acc u_acc (
                .aclk(aclk),
                .aresetn(aresetn),
                .bus(acc_bus[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    // address and data are caught separately, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            awaddr_r <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_have_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (!aw_have_r) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_have_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (!w_have_r) begin
            s_axi_wready <= 1'b1;
        end
    end

    // the write acts once, in the cycle both halves are present
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    assign w_idx = acc_idx(awaddr_r);
    assign w_ovf = awaddr_r[OVF_SEL_BIT];
    // only a full-word write of the key counts as a confirmed clear
    assign gclr_go = do_write && awaddr_r == OFS_GCLR &&
        wstrb_r == 4'hf && wdata_r == GCLR_KEY;                   // [RULE7]

    // overflow words take no writes and answer with an error
    always_comb begin
        w_ok = 1'b0;
        case (awaddr_r)
            OFS_CTRL, OFS_GCLR, OFS_ISTS, OFS_IMSK, OFS_STAT: w_ok = 1'b1;
            default: w_ok = acc_avail(w_idx, fwd_only_r) && !w_ovf;   // [RULE11] [RULE8]
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control and interrupt registers
    // ------------------------------------------------------------
    // direction mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_only_r <= 1'b0;
        end else if (do_write && awaddr_r == OFS_CTRL && wstrb_r[0]) begin
            fwd_only_r <= wdata_r[CTRL_FWD_BIT];                  // [RULE8]
        end
    end

    // mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imsk_r <= '0;
        end else if (do_write && awaddr_r == OFS_IMSK && wstrb_r[0]) begin
            imsk_r <= wdata_r[ACC_N-1:0];
        end
    end

    // sticky wrap events, a new wrap wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ists_r <= '0;
        end else if (do_write && awaddr_r == OFS_ISTS && wstrb_r[0]) begin
            ists_r <= (ists_r & ~wdata_r[ACC_N-1:0]) | wrap_v;    // [RULE3]
        end else begin
            ists_r <= ists_r | wrap_v;                            // [RULE3]
        end
    end

    // indications; warning stays until software clears the event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warn <= 1'b0;
            irq <= 1'b0;
        end else begin
            warn <= |ists_r;                                       // [RULE3]
            irq <= |(ists_r & imsk_r);
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_word;
    logic rd_ok;
    logic [2:0] r_idx;

    assign r_idx = acc_idx(s_axi_araddr);

    // full total is ovf * ten million + reading, software forms it
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            OFS_CTRL: rd_word[CTRL_FWD_BIT] = fwd_only_r;
            OFS_GCLR: rd_word = '0;
            OFS_ISTS: rd_word[ACC_N-1:0] = ists_r;
            OFS_IMSK: rd_word[ACC_N-1:0] = imsk_r;
            OFS_STAT: begin
                rd_word[STAT_REV_BIT] = flow_reverse;
                rd_word[STAT_WARN_BIT] = warn;
            end
            default: begin
                if (acc_avail(r_idx, fwd_only_r)) begin              // [RULE8]
                    if (s_axi_araddr[OVF_SEL_BIT]) begin
                        rd_word[OVF_W-1:0] = acc_ovf[r_idx];         // [RULE12]
                    end else begin
                        rd_word[ACC_W-1:0] = acc_val[r_idx];         // [RULE9] [RULE10]
                    end
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // one read at a time; arready drops until the data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ==== testbench/ftb_checker.sv ====
`timescale 1ns/1ps
module ftb_checker
    import ftb_pkg::*;
(
    // clock and reset
    input wire logic aclk, aresetn,
    // write side
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid, s_axi_bready,
    // read side
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // flow and indications
    input wire logic [QTY_N-1:0] flow_inc,
    input wire logic flow_reverse, warn, irq
);
    // ------------------------------------------------------------
    // handshake steps
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_r_take;
        s_axi_rvalid && s_axi_rready;
    endsequence
    property p_b_after;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    property p_r_after;
        s_ar_take |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_r_done;
        s_r_take |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    // masked status is a subset of all status
    property p_irq_warn;
        irq |-> warn;
    endproperty
    // a warning can only come from a recent wrap
    property p_warn_cause;
        $rose(warn) |-> $past(flow_inc, 2) != 3'h0 || $past(flow_inc, 3) != 3'h0
            || $past(flow_inc, 4) != 3'h0 || $past(flow_inc, 5) != 3'h0;
    endproperty
    property p_reset;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !warn && !irq;
    endproperty
    a_b_after: assert property (p_b_after) else $error("no write response");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_b_done: assert property (p_b_done) else $error("write channel not freed");
    a_r_after: assert property (p_r_after) else $error("no read response");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_r_done: assert property (p_r_done) else $error("read channel not freed");
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    a_irq_warn: assert property (p_irq_warn) else $error("irq without warn");
    a_warn_cause: assert property (p_warn_cause) else $error("warn without wrap");
    a_reset: assert property (p_reset) else $error("outputs busy in reset");
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import ftb_pkg::*;
    // ------------------------------------------------------------
    // stimulus and model state
    // ------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_araddr = 32'h0, s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, flow_reverse = 1'b0;
    logic [2:0] flow_inc = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic warn, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    int num_errors = 0, checks = 0, seed = 90, ists = 0, imsk = 0, fwd = 0;
    int mv[6], mo[6];
    ftb_top u_dut (.*);
    always #2.5 aclk = ~aclk;
    // ------------------------------------------------------------
    // report and compare
    // ------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ------------------------------------------------------------
    // bus master: holds each channel until its ready
    // ------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 40) begin
            num_errors++;
            results;
        end
    endtask
    task automatic rd(input logic [31:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 40) begin
            num_errors++;
            results;
        end
    endtask
    // ------------------------------------------------------------
    // model helpers
    // ------------------------------------------------------------
    task automatic ld(input int i, input int v);
        wr(OFS_ACC_BASE + 8 * i, v);
        mv[i] = v > 10000000 ? 10000000 : v;
        mo[i] = 0;
    endtask
    // one flow unit; reverse units vanish in forward-only mode
    task automatic pulse(input int q, input int rv);
        int i;
        i = q * 2 + rv;
        @(posedge aclk);
        flow_inc <= 3'h1 << q;
        flow_reverse <= rv[0];
        @(posedge aclk);
        flow_inc <= 3'h0;
        if (!(fwd && rv)) begin
            mv[i]++;
            if (mv[i] >= 10000000) begin
                mv[i] -= 10000000;
                if (mo[i] < 65535) mo[i]++;
                ists |= 1 << i;
            end
        end
    endtask
    task automatic check_all(input int t);
        for (int i = 0; i < 6; i++) begin
            logic rs;
            rs = fwd && i % 2;
            rd(OFS_ACC_BASE + 8 * i);
            chk(d, rs ? 0 : mv[i]);
            chk(r, rs ? RESP_SLVERR : RESP_OKAY);
            rd(OFS_ACC_BASE + 8 * i + 4);
            chk(d, rs ? 0 : mo[i]);
        end
        rd(OFS_ISTS);
        chk(d, ists);
        chk(warn, ists != 0);
        chk(irq, (ists & imsk) != 0);
        rd(OFS_STAT);
        chk(d, {30'h0, ists != 0, flow_reverse});
        rd(OFS_CTRL);
        chk(d, fwd);
        rd(OFS_IMSK);
        chk(d, imsk);
        $display("test %0d done", t);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        check_all(1);
        for (int i = 0; i < 6; i++) ld(i, {$random(seed)} % 10000001);
        ld(0, 32'h00ffffff);
        ld(1, 32'h01000005);
        check_all(2);
        // random traffic in both directions, first mass unit wraps
        for (int k = 0; k < 60; k++) pulse({$random(seed)} % 3, {$random(seed)} % 2);
        check_all(3);
        // every accumulator one unit short of the limit
        wr(OFS_IMSK, 32'h5);
        imsk = 5;
        for (int i = 0; i < 6; i++) ld(i, 9999999);
        for (int i = 0; i < 6; i++) pulse(i / 2, i % 2);
        check_all(4);
        wr(OFS_ACC_BASE + 4, 32'h7);
        chk(r, RESP_SLVERR);
        wr(32'h100, 32'h1);
        chk(r, RESP_SLVERR);
        rd(32'h100);
        chk(r, RESP_SLVERR);
        ld(1, 0);
        ld(2, 123);
        check_all(5);
        wr(OFS_ISTS, 32'h3f);
        ists = 0;
        check_all(6);
        // forward-only drops reverse units and hides reverse slots
        wr(OFS_CTRL, 32'h1);
        fwd = 1;
        pulse(0, 1);
        pulse(1, 0);
        wr(OFS_ACC_BASE + 8, 32'h5);
        chk(r, RESP_SLVERR);
        check_all(7);
        wr(OFS_CTRL, 32'h0);
        fwd = 0;
        check_all(8);
        // an unconfirmed or partly strobed clear does nothing; strobes merge bytes
        wr(OFS_GCLR, 32'h1234);
        s_axi_wstrb <= 4'h7;
        wr(OFS_GCLR, GCLR_KEY);
        s_axi_wstrb <= 4'h1;
        wr(OFS_ACC_BASE + 16, 32'hffffff55);
        s_axi_wstrb <= 4'hf;
        mv[2] = (mv[2] & 32'hffff00) | 32'h55;
        if (mv[2] > 10000000) mv[2] = 10000000;
        mo[2] = 0;
        check_all(9);
        wr(OFS_GCLR, GCLR_KEY);
        for (int i = 0; i < 6; i++) mv[i] = 0;
        for (int i = 0; i < 6; i++) mo[i] = 0;
        check_all(10);
        // mid-run reset clears the mask; status and mode are already zero before it
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        ists = 0;
        imsk = 0;
        fwd = 0;
        check_all(11);
        results;
    end
endmodule
bind ftb_top ftb_checker u_chk (.*);
